// File: src/fes_pkg.sv
// Shared constants for the flash erase and status sequencer host.
// Assumes a 25 MHz aclk; bus timings are derived from it here.
package fes_pkg;
    localparam int CLK_MHZ = 25;
    localparam int T_WRITE_NS = 100;
    localparam int T_RECOVER_NS = 40;
    localparam int T_READ_NS = 120;
    localparam int WR_CYC = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
    localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

    localparam int SR_READY = 7;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_WRITE_ERR = 4;
    localparam int SR_VPP_ERR = 3;
    localparam int SR_PROTECT = 1;
    localparam logic [7:0] SR_MASK = 8'hFE;
    localparam logic [7:0] XSR_MASK = 8'h80;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_PROT = 3;
    localparam int CTRL_DEFER = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_RES_LSB = 4;
    localparam int STAT_SR_LSB = 8;
    localparam int STAT_XSR_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        FES_OP_NONE = 3'h0,
        FES_OP_BLOCK = 3'h1,
        FES_OP_CHIP = 3'h2,
        FES_OP_CLEAR = 3'h3,
        FES_OP_XSTAT = 3'h4,
        FES_OP_ARRAY = 3'h5
    } fes_op_t;

    typedef enum logic [2:0] {
        FES_RES_OK = 3'h0,
        FES_RES_VPP = 3'h1,
        FES_RES_PROTECT = 3'h2,
        FES_RES_SEQUENCE = 3'h3,
        FES_RES_ERASE = 3'h4
    } fes_res_t;

    typedef enum logic [2:0] {
        FES_ST_IDLE = 3'b000,
        FES_ST_WR = 3'b001,
        FES_ST_REC = 3'b011,
        FES_ST_RD = 3'b010,
        FES_ST_NEXT = 3'b110
    } fes_state_t;

    typedef enum logic [3:0] {
        FES_PH_SR_CMD = 4'h0,
        FES_PH_POLL_PRE = 4'h1,
        FES_PH_SETUP = 4'h2,
        FES_PH_CONFIRM = 4'h3,
        FES_PH_POLL = 4'h4,
        FES_PH_ARRAY = 4'h5,
        FES_PH_CLEAR = 4'h6,
        FES_PH_X_CMD = 4'h7,
        FES_PH_X_RD = 4'h8
    } fes_phase_t;
endpackage

// File: src/fes_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are quasi-static while they are sampled.
`timescale 1ns/1ps
module fes_sync #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// File: src/fes_top.sv
// Host-side sequencer that erases a parallel flash and checks its status.
// Assumes software on AXI4-Lite and a flash whose pins are wired directly.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fes_top import fes_pkg::*; #(
    parameter int ADDR_W = 21,
    parameter logic [7:0] CMD_CLEAR_STATUS = 8'h00,
    parameter logic [7:0] CMD_READ_XSTATUS = 8'h00
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ADDR_W-1:0] fl_addr,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [7:0] fl_dq_i,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_rp_n
);
    localparam int CNT_W = 4;

    logic [7:0] dq_sync;
    logic aw_rdy_q, aw_rdy_d, b_vld_q, b_vld_d;
    logic [1:0] b_resp_q, b_resp_d, r_resp_q, r_resp_d;
    logic ar_rdy_q, ar_rdy_d, r_vld_q, r_vld_d;
    logic [31:0] r_data_q, r_data_d;
    logic [4:0] ctrl_q, ctrl_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic err_q, err_d, refused_q, refused_d;
    fes_res_t res_q, res_d;
    logic [7:0] sr_q, sr_d, xsr_q, xsr_d;
    fes_state_t st_q, st_d;
    fes_phase_t ph_q, ph_d;
    fes_op_t op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] fa_q, fa_d;
    logic [7:0] fdo_q, fdo_d;
    logic foe_q, foe_d, ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, rp_n_q, rp_n_d;
    logic wr_go, launch;
    fes_op_t new_op;

    fes_sync #(.W(8)) u_dq_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(fl_dq_i),
        .q(dq_sync)
    );

    // Write and address are taken together, so a lone channel simply waits.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !aw_rdy_q && !b_vld_q;
    assign new_op = fes_op_t'(s_axi_wdata[CTRL_OP_LSB +: 3]);
    assign launch = aw_rdy_q && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]
        && st_q == FES_ST_IDLE;

    always_comb begin
        aw_rdy_d = wr_go;
        b_vld_d = b_vld_q;
        b_resp_d = b_resp_q;
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        if (aw_rdy_q) begin
            b_vld_d = 1'b1;
            b_resp_d = RESP_OKAY;
            unique case (s_axi_awaddr)
                REG_CTRL: begin
                    if (s_axi_wstrb[0]) begin
                        ctrl_d = s_axi_wdata[4:0];
                    end
                end
                REG_ADDR: begin
                    for (int i = 0; i < ADDR_W; i++) begin
                        if (s_axi_wstrb[i / 8]) begin
                            addr_d[i] = s_axi_wdata[i];
                        end
                    end
                end
                REG_STAT: b_resp_d = RESP_OKAY;
                default: b_resp_d = RESP_SLVERR;
            endcase
        end else if (b_vld_q && s_axi_bready) begin
            b_vld_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_q <= 1'b0;
            b_vld_q <= 1'b0;
            b_resp_q <= RESP_OKAY;
            ctrl_q <= '0;
            addr_q <= '0;
        end else begin
            aw_rdy_q <= aw_rdy_d;
            b_vld_q <= b_vld_d;
            b_resp_q <= b_resp_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
        end
    end

    always_comb begin
        ar_rdy_d = s_axi_arvalid && !ar_rdy_q && !r_vld_q;
        r_vld_d = r_vld_q;
        r_data_d = r_data_q;
        r_resp_d = r_resp_q;
        if (ar_rdy_q) begin
            r_vld_d = 1'b1;
            r_data_d = '0;
            r_resp_d = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: r_data_d[4:0] = ctrl_q;
                REG_ADDR: r_data_d[ADDR_W-1:0] = addr_q;
                REG_STAT: begin
                    r_data_d[STAT_BUSY] = st_q != FES_ST_IDLE;
                    r_data_d[STAT_ERR] = err_q;
                    r_data_d[STAT_REFUSED] = refused_q;
                    r_data_d[STAT_RES_LSB +: 3] = res_q;
                    r_data_d[STAT_SR_LSB +: 8] = sr_q;
                    r_data_d[STAT_XSR_LSB +: 8] = xsr_q;
                end
                default: r_resp_d = RESP_SLVERR;
            endcase
        end else if (r_vld_q && s_axi_rready) begin
            r_vld_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_q <= 1'b0;
            r_vld_q <= 1'b0;
            r_data_q <= '0;
            r_resp_q <= RESP_OKAY;
        end else begin
            ar_rdy_q <= ar_rdy_d;
            r_vld_q <= r_vld_d;
            r_data_q <= r_data_d;
            r_resp_q <= r_resp_d;
        end
    end

    // Flash sequencer: every bus write and read runs through WR/REC or RD,
    // and NEXT picks the following step from the phase.
    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        op_d = op_q;
        cnt_d = cnt_q;
        fa_d = fa_q;
        fdo_d = fdo_q;
        foe_d = foe_q;
        ce_n_d = ce_n_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        rp_n_d = 1'b1;
        err_d = err_q;
        refused_d = refused_q;
        res_d = res_q;
        sr_d = sr_q;
        xsr_d = xsr_q;
        unique case (st_q)
            FES_ST_IDLE: begin
                if (launch) begin
                    refused_d = 1'b0;
                    op_d = new_op;
                    st_d = FES_ST_NEXT;
                    unique case (new_op)
                        FES_OP_BLOCK, FES_OP_CHIP: begin
                            if (err_q) begin
                                refused_d = 1'b1;
                                st_d = FES_ST_IDLE;
                            end
                            ph_d = FES_PH_SR_CMD;
                            fdo_d = CMD_READ_STATUS;
                            fa_d = addr_q;
                        end
                        FES_OP_CLEAR: begin
                            ph_d = FES_PH_CLEAR;
                            fdo_d = CMD_CLEAR_STATUS;
                        end
                        FES_OP_XSTAT: begin
                            ph_d = FES_PH_X_CMD;
                            fdo_d = CMD_READ_XSTATUS;
                        end
                        FES_OP_ARRAY: begin
                            ph_d = FES_PH_ARRAY;
                            fdo_d = CMD_READ_ARRAY;
                        end
                        default: st_d = FES_ST_IDLE;
                    endcase
                    if (st_d == FES_ST_NEXT) begin
                        st_d = FES_ST_WR;
                        cnt_d = '0;
                        foe_d = 1'b1;
                        ce_n_d = 1'b0;
                        we_n_d = 1'b0;
                    end
                end
            end
            FES_ST_WR: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WR_CYC - 1)) begin
                    we_n_d = 1'b1;
                    ce_n_d = 1'b1;
                    cnt_d = '0;
                    st_d = FES_ST_REC;
                end
            end
            FES_ST_REC: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(REC_CYC - 1)) begin
                    foe_d = 1'b0;
                    st_d = FES_ST_NEXT;
                end
            end
            FES_ST_RD: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RD_CYC + SYNC_CYC - 1)) begin
                    ce_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    st_d = FES_ST_NEXT;
                    if (ph_q == FES_PH_X_RD) begin
                        xsr_d = dq_sync & XSR_MASK;
                    end else if (dq_sync[SR_READY]) begin
                        // Lower bits are stored only once ready shows.
                        sr_d = dq_sync & SR_MASK;
                    end
                end
            end
            FES_ST_NEXT: begin
                cnt_d = '0;
                st_d = FES_ST_RD;
                ce_n_d = 1'b0;
                oe_n_d = 1'b0;
                unique case (ph_q)
                    FES_PH_SR_CMD: ph_d = FES_PH_POLL_PRE;
                    FES_PH_POLL_PRE: begin
                        if (sr_q[SR_READY]) begin
                            ph_d = FES_PH_SETUP;
                            st_d = FES_ST_WR;
                            oe_n_d = 1'b1;
                            we_n_d = 1'b0;
                            foe_d = 1'b1;
                            fdo_d = op_q == FES_OP_CHIP ? CMD_CHIP_SETUP
                                : CMD_BLOCK_SETUP;
                        end
                    end
                    FES_PH_SETUP: begin
                        ph_d = FES_PH_CONFIRM;
                        st_d = FES_ST_WR;
                        oe_n_d = 1'b1;
                        we_n_d = 1'b0;
                        foe_d = 1'b1;
                        fdo_d = CMD_CONFIRM;
                        sr_d[SR_READY] = 1'b0;
                    end
                    FES_PH_CONFIRM: ph_d = FES_PH_POLL;
                    FES_PH_POLL: begin
                        if (sr_q[SR_READY]) begin
                            // Each bit is read once the engine has finished,
                            // since the device updates it only then.
                            if (!ctrl_q[CTRL_DEFER]) begin
                                if (sr_q[SR_VPP_ERR]) begin
                                    res_d = FES_RES_VPP;
                                end else if (ctrl_q[CTRL_PROT] && sr_q[SR_PROTECT]) begin
                                    // Abort only; lock values need identifier mode.
                                    res_d = FES_RES_PROTECT;
                                end else if (sr_q[SR_ERASE_ERR] && sr_q[SR_WRITE_ERR]) begin
                                    res_d = FES_RES_SEQUENCE;
                                end else if (sr_q[SR_ERASE_ERR]) begin
                                    res_d = FES_RES_ERASE;
                                end else begin
                                    res_d = FES_RES_OK;
                                end
                                err_d = res_d != FES_RES_OK;
                            end
                            ph_d = FES_PH_ARRAY;
                            st_d = FES_ST_WR;
                            oe_n_d = 1'b1;
                            we_n_d = 1'b0;
                            foe_d = 1'b1;
                            fdo_d = CMD_READ_ARRAY;
                        end
                    end
                    FES_PH_X_CMD: ph_d = FES_PH_X_RD;
                    FES_PH_CLEAR: begin
                        err_d = 1'b0;
                        res_d = FES_RES_OK;
                        sr_d = sr_q & ~8'h3A;
                        st_d = FES_ST_IDLE;
                        ce_n_d = 1'b1;
                        oe_n_d = 1'b1;
                    end
                    default: begin
                        st_d = FES_ST_IDLE;
                        ce_n_d = 1'b1;
                        oe_n_d = 1'b1;
                    end
                endcase
            end
            default: st_d = FES_ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= FES_ST_IDLE;
            ph_q <= FES_PH_SR_CMD;
            op_q <= FES_OP_NONE;
            cnt_q <= '0;
            fa_q <= '0;
            fdo_q <= '0;
            foe_q <= 1'b0;
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            rp_n_q <= 1'b0;
            err_q <= 1'b0;
            refused_q <= 1'b0;
            res_q <= FES_RES_OK;
            sr_q <= '0;
            xsr_q <= '0;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            fa_q <= fa_d;
            fdo_q <= fdo_d;
            foe_q <= foe_d;
            ce_n_q <= ce_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            rp_n_q <= rp_n_d;
            err_q <= err_d;
            refused_q <= refused_d;
            res_q <= res_d;
            sr_q <= sr_d;
            xsr_q <= xsr_d;
        end
    end

    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = aw_rdy_q;
    assign s_axi_bvalid = b_vld_q;
    assign s_axi_bresp = b_resp_q;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = r_vld_q;
    assign s_axi_rdata = r_data_q;
    assign s_axi_rresp = r_resp_q;
    assign fl_addr = fa_q;
    assign fl_dq_o = fdo_q;
    assign fl_dq_oe = foe_q;
    assign fl_ce_n = ce_n_q;
    assign fl_we_n = we_n_q;
    assign fl_oe_n = oe_n_q;
    assign fl_rp_n = rp_n_q;
endmodule

// File: verif/fes_flash_model.sv
// Behavioural parallel flash answering the sequencer's strobes.
// Assumes address and data hold until the write strobes rise.
`timescale 1ns/1ps
module fes_flash_model #(
    parameter logic [7:0] CLR = 8'hC3,
    parameter logic [7:0] XRD = 8'h3C
) (
    input wire logic [20:0] fl_addr,
    input wire logic [7:0] dq_wire,
    output logic [7:0] dq_drv,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_rp_n,
    input wire logic [2:0] err_kind,
    input wire logic [15:0] busy_ns,
    input wire logic xsr_avail
);
    logic [6:0] sr_q;
    logic [1:0] mode_q;
    logic [7:0] setup_q;
    logic [20:0] ers_addr;
    logic busy = 1'b0;
    logic wr_on = 1'b0;
    logic [7:0] rd_val;
    logic [7:0] last_q = 8'h00;
    always_comb begin
        case (mode_q)
            2'd0: rd_val = fl_addr[7:0] ^ 8'hA5;
            2'd2: rd_val = {xsr_avail, 7'h5A};
            default: rd_val = busy ? {1'b0, ~sr_q} : {1'b1, sr_q};
        endcase
    end
    always @* if (!fl_ce_n && !fl_oe_n) last_q = rd_val;
    // A released bus shows the inverse of the last value, so stale data cannot pass.
    assign dq_drv = (!fl_ce_n && !fl_oe_n) ? rd_val : ~last_q;
    always @(fl_we_n or fl_ce_n or fl_rp_n) begin
        if (!fl_rp_n) begin
            // Nothing here suspends, so bits 6 and 2 stay 0; bit 0 is junk.
            sr_q = 7'h01;
            mode_q = 2'd0;
            setup_q = 8'h00;
            wr_on = 1'b0;
        end else if (!fl_we_n && !fl_ce_n) begin
            wr_on = 1'b1;
        end else if (wr_on) begin
            wr_on = 1'b0;
            if (setup_q != 8'h00) begin
                mode_q = 2'd1;
                if (dq_wire == 8'hD0 && err_kind != 3'd4) begin
                    ers_addr = fl_addr;
                    busy = 1'b1;
                end else begin
                    sr_q = sr_q | 7'h30;
                end
                setup_q = 8'h00;
            end else if (dq_wire == 8'h20 || dq_wire == 8'h30) begin
                setup_q = dq_wire;
                mode_q = 2'd1;
            end else if (dq_wire == 8'h70) begin
                mode_q = 2'd1;
            end else if (dq_wire == CLR) begin
                sr_q = sr_q & 7'h45;
            end else if (dq_wire == XRD) begin
                mode_q = 2'd2;
            end else if (dq_wire == 8'hFF) begin
                mode_q = 2'd0;
            end
        end
    end
    // Faults of kinds 1 to 3 are set at the end of an erase and accumulate; kind 4 is set at the confirm write.
    always @(posedge busy) begin
        #(busy_ns);
        case (err_kind)
            3'd1: sr_q = sr_q | 7'h28;
            3'd2: sr_q = sr_q | 7'h22;
            3'd3: sr_q = sr_q | 7'h20;
            default: ;
        endcase
        busy = 1'b0;
    end
endmodule

// File: verif/fes_assertions.sv
// Concurrent checks on the sequencer's register bus and flash strobes.
// Assumes it is bound into fes_top and sees only its ports.
`timescale 1ns/1ps
module fes_assertions #(
    parameter int ADDR_W = 21
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic [7:0] fl_dq_o,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n
);
    logic we_q, we_d, start;
    logic [7:0] cmd_q, cmd_d;
    logic [ADDR_W-1:0] adr_q, adr_d;
    assign start = !fl_we_n && we_q;
    always_comb begin
        we_d = fl_we_n;
        cmd_d = start ? fl_dq_o : cmd_q;
        adr_d = start ? fl_addr : adr_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            we_q <= 1'b1;
            cmd_q <= 8'h00;
            adr_q <= '0;
        end else begin
            we_q <= we_d;
            cmd_q <= cmd_d;
            adr_q <= adr_d;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    aw_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> s_axi_awready && s_axi_wready) else $error("write not taken");
    b_answer_a: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
    ar_take_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready) else $error("read not taken");
    r_answer_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    we_width_a: assert property (start |-> !fl_we_n [*3] ##1 fl_we_n)
        else $error("write strobe width wrong");
    rd_width_a: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*5] ##1 fl_oe_n)
        else $error("read strobe width wrong");
    no_fight_a: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n && !fl_ce_n)
        else $error("host drives during read");
    wr_steady_a: assert property (!fl_we_n && !start |-> fl_dq_oe && !fl_ce_n
        && $stable(fl_dq_o) && $stable(fl_addr)) else $error("write bus moved");
    confirm_order_a: assert property (start && fl_dq_o == 8'hD0
        |-> cmd_q == 8'h20 || cmd_q == 8'h30) else $error("confirm without setup");
    setup_order_a: assert property (start && (fl_dq_o == 8'h20 || fl_dq_o == 8'h30)
        |-> cmd_q == 8'h70) else $error("setup without status mode");
    block_addr_a: assert property (start && fl_dq_o == 8'hD0 && cmd_q == 8'h20
        |-> fl_addr == adr_q) else $error("confirm address differs");
    cover property (start && fl_dq_o == 8'hD0 && cmd_q == 8'h20);
    cover property (start && fl_dq_o == 8'hD0 && cmd_q == 8'h30);
    cover property (start && fl_dq_o == 8'hFF);
endmodule
bind fes_top fes_assertions #(.ADDR_W(ADDR_W)) fes_assertions_inst (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .fl_addr, .fl_dq_o, .fl_dq_oe,
    .fl_ce_n, .fl_we_n, .fl_oe_n);

// File: verif/tb_top.sv
// Self-checking bench for the erase and status sequencer host.
// Assumes the package, flash model and bound checker compile first.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top import fes_pkg::*; ();
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [20:0] fl_addr;
    logic [7:0] fl_dq_o, fl_dq_i, dq_drv;
    logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_rp_n;
    logic [2:0] err_kind = 3'h0;
    logic [15:0] busy_ns = 16'h00C8;
    logic xsr_avail = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 41890;
    fes_top #(.ADDR_W(21), .CMD_CLEAR_STATUS(8'hC3), .CMD_READ_XSTATUS(8'h3C)) fes_top_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fl_addr, .fl_dq_o, .fl_dq_oe,
        .fl_dq_i, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_rp_n);
    // Shared data wire: the enabled side drives it.
    assign fl_dq_i = fl_dq_oe ? fl_dq_o : dq_drv;
    fes_flash_model #(.CLR(8'hC3), .XRD(8'h3C)) fm_inst (.fl_addr, .dq_wire(fl_dq_i),
        .dq_drv, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_rp_n, .err_kind, .busy_ns, .xsr_avail);
    always #20 aclk = ~aclk;
    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        @(posedge aclk);
    endtask
    task automatic run(input logic [2:0] op, input logic p, input logic dfr,
        output logic [31:0] st);
        wr(REG_CTRL, {27'h0, dfr, p, op}, RESP_OKAY);
        do rd(REG_STAT, st, RESP_OKAY); while (st[STAT_BUSY] !== 1'b0);
    endtask
    function automatic logic [7:0] err_bits(input logic [2:0] k);
        case (k)
            3'd1: return 8'h28;
            3'd2: return 8'h22;
            3'd3: return 8'h20;
            3'd4: return 8'h30;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [2:0] calc(input logic [7:0] s, input logic p);
        if (s[3]) return 3'h1;
        if (p && s[1]) return 3'h2;
        if (s[5] && s[4]) return 3'h3;
        if (s[5]) return 3'h4;
        return 3'h0;
    endfunction
    initial begin
        logic [31:0] st, r;
        logic [20:0] blk;
        logic [2:0] k, exp_res;
        logic [7:0] exp_sr;
        logic exp_err, dfr;
        int i;
        exp_sr = 8'h80;
        exp_res = 3'h0;
        exp_err = 1'b0;
        repeat (5) @(posedge aclk);
        `CHK(fl_rp_n, 1'b0)
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_STAT, st, RESP_OKAY);
        `CHK(st[STAT_BUSY], 1'b0)
        `CHK(fl_rp_n, 1'b1)
        rd(4'hC, st, RESP_SLVERR);
        `CHK(st, 32'h0)
        wr(4'hC, 32'h1, RESP_SLVERR);
        for (i = 0; i < 2; i++) begin
            xsr_avail <= i[0];
            run(FES_OP_XSTAT, 1'b0, 1'b0, st);
            `CHK(st[23:16], {i[0], 7'h00})
        end
        run(FES_OP_ARRAY, 1'b0, 1'b0, st);
        `CHK(fm_inst.mode_q, 2'd0)
        for (i = 0; i < 14; i++) begin
            r = $random(seed);
            k = (i < 5) ? i[2:0] : r[6:4] % 3'd5;
            dfr = (i % 4 == 1);
            err_kind <= k;
            busy_ns <= 16'd200 + {5'h0, r[15:8], 3'h0};
            blk = r[31:11];
            wr(REG_ADDR, {11'h0, blk}, RESP_OKAY);
            run(r[0] ? FES_OP_CHIP : FES_OP_BLOCK, r[1], dfr, st);
            exp_sr = exp_sr | err_bits(k);
            if (!dfr) begin
                exp_res = calc(exp_sr, r[1]);
                exp_err = exp_res != 3'h0;
            end
            `CHK(st[15:8], {exp_sr[7:1], 1'b0})
            `CHK(st[6:4], exp_res)
            `CHK(st[STAT_ERR], exp_err)
            `CHK(fm_inst.mode_q, 2'd0)
            if (!r[0] && k != 3'd4) `CHK(fm_inst.ers_addr, blk)
            if (exp_err) begin
                run(FES_OP_BLOCK, 1'b0, 1'b0, st);
                `CHK(st[STAT_REFUSED], 1'b1)
                run(FES_OP_CLEAR, 1'b0, 1'b0, st);
                exp_sr = exp_sr & 8'hC5;
                exp_res = 3'h0;
                exp_err = 1'b0;
                `CHK(st[STAT_ERR], 1'b0)
                `CHK(st[15:8], {exp_sr[7:1], 1'b0})
            end
        end
        wrap_up();
    end
endmodule
